// [hdl/epi_pkg.sv]
// Package with the register map, field layout, encodings and timing of the pin interrupt block.
package epi_pkg;

  localparam logic [31:0] EPI_ADDR_FLAGS     = 32'h4000_a814;
  localparam logic [31:0] EPI_ADDR_CFG_A     = 32'h4000_a860;
  localparam logic [31:0] EPI_ADDR_CFG_B     = 32'h4000_a864;
  localparam logic [31:0] EPI_ADDR_CFG_C     = 32'h4000_a868;
  localparam logic [31:0] EPI_ADDR_CFG_D     = 32'h4000_a86c;
  localparam logic [31:0] EPI_ADDR_SEL_C     = 32'h4000_bc14;
  localparam logic [31:0] EPI_ADDR_SEL_D     = 32'h4000_bc18;
  localparam logic [31:0] EPI_ADDR_WAKE_FILT = 32'h4000_bc1c;
  localparam logic [31:0] EPI_ADDR_DBG_CFG   = 32'h4000_bc00;

  localparam logic [4:0]  EPI_SEL_C_RESET    = 5'h0f;
  localparam logic [4:0]  EPI_SEL_D_RESET    = 5'h10;
  localparam logic [4:0]  EPI_SEL_LAST       = 5'h17;
  localparam logic [2:0]  EPI_DBG_RESET      = 3'h2;

  localparam int EPI_CFG_FILT_BIT  = 8;
  localparam int EPI_CFG_MODE_LSB  = 5;
  localparam int EPI_CFG_MODE_MSB  = 7;
  localparam int EPI_SEL_MSB       = 4;
  localparam int EPI_WF_PORT_BIT   = 0;
  localparam int EPI_WF_SER1_BIT   = 1;
  localparam int EPI_WF_SER2_BIT   = 2;
  localparam int EPI_WF_INTD_BIT   = 3;
  localparam int EPI_DBG_RSVD_BIT  = 3;
  localparam int EPI_DBG_REG_BIT   = 4;
  localparam int EPI_DBG_DIS_BIT   = 5;
  localparam int EPI_NUM_INT       = 4;
  localparam int EPI_NUM_PINS      = 24;
  localparam int EPI_IDX_PORT_A_PIN2 = 2;
  localparam int EPI_IDX_PORT_B_PIN2 = 10;

  localparam int EPI_CLK_PERIOD_NS  = 4;
  localparam int EPI_FILT_SAMPLE_NS = 16;
  localparam int EPI_FILT_DIV =
    (EPI_FILT_SAMPLE_NS + EPI_CLK_PERIOD_NS - 1) / EPI_CLK_PERIOD_NS;
  localparam logic [1:0] EPI_FILT_DIV_LAST = 2'(EPI_FILT_DIV - 1);
  localparam logic [1:0] EPI_FILT_STABLE   = 2'h3;

  localparam logic [1:0] EPI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] EPI_RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    EPI_MODE_OFF  = 3'h0,
    EPI_MODE_RISE = 3'h1,
    EPI_MODE_FALL = 3'h2,
    EPI_MODE_BOTH = 3'h3,
    EPI_MODE_HIGH = 3'h4,
    EPI_MODE_LOW  = 3'h5
  } epi_mode_e;

  typedef struct packed {
    logic      filt;
    epi_mode_e mode;
  } epi_cfg_s;

  typedef struct packed {
    logic int_d;
    logic serial2;
    logic serial1;
    logic port;
  } epi_wake_s;

endpackage : epi_pkg

// [hdl/epi_filter.sv]
// Digital glitch filter: a bit follows its input only after it has been stable for some samples.
`timescale 1ns/100ps
module epi_filter #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic [W-1:0] en,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import epi_pkg::*;

  logic [W-1:0]      state;
  logic [W-1:0]      next_state;
  logic [W-1:0][1:0] cnt;
  logic [W-1:0][1:0] next_cnt;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    for (int i = 0; i < W; i++) begin
      if (tick) begin
        if (din[i] == state[i]) begin
          next_cnt[i] = 2'h0;
        end else if (cnt[i] == EPI_FILT_STABLE - 2'h1) begin
          next_state[i] = din[i];
          next_cnt[i]   = 2'h0;
        end else begin
          next_cnt[i] = cnt[i] + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Disabled bits pass straight through so that an unfiltered source loses no latency.
  assign dout = (en & state) | (~en & din);

endmodule : epi_filter

// [hdl/epi_trigger.sv]
// Trigger detection: edge and level conditions per interrupt source.
`timescale 1ns/100ps
module epi_trigger #(
  parameter int W = 4
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic      [W-1:0]       level,
  input  epi_pkg::epi_mode_e [W-1:0]   mode,
  output logic           [W-1:0]       hit
);
  import epi_pkg::*;

  logic [W-1:0] prev;
  logic [W-1:0] next_prev;

  always_comb begin
    next_prev = level;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '0;
    end else begin
      prev <= next_prev;
    end
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      unique case (mode[i])
        EPI_MODE_OFF:  hit[i] = 1'b0;
        EPI_MODE_RISE: hit[i] = level[i] & ~prev[i];
        EPI_MODE_FALL: hit[i] = ~level[i] & prev[i];
        EPI_MODE_BOTH: hit[i] = level[i] ^ prev[i];
        EPI_MODE_HIGH: hit[i] = level[i];
        EPI_MODE_LOW:  hit[i] = ~level[i];
        // Reserved codes 6 and 7 never raise an interrupt.
        default:       hit[i] = 1'b0;
      endcase
    end
  end

endmodule : epi_trigger

// [hdl/epi_top.sv]
// Top of the external pin interrupt block: AXI4-Lite registers, routing, filters and wake-ups.
`timescale 1ns/100ps
module epi_top (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [7:0]            port_a_pins,
  input  wire logic [7:0]            port_b_pins,
  input  wire logic [7:0]            port_c_pins,
  input  wire logic                  ext_int_a_pin,
  input  wire logic                  ext_int_b_pin,
  input  wire logic [23:0]           port_wake_monitor_mask,
  input  wire logic                  debug_active,
  input  wire logic                  debug_rsvd_load,
  input  wire logic                  debug_rsvd_value,
  output logic [3:0]                 ext_int_pending,
  output epi_pkg::epi_wake_s         wake,
  output logic                       debug_override_permit,
  output logic                       regulator_pin_override_en
);
  import epi_pkg::*;

  // Pin synchroniser; stage one is read only by stage two.
  logic [25:0] sync1;
  logic [25:0] sync2;
  logic [25:0] next_sync1;

  always_comb begin
    next_sync1 = {ext_int_b_pin, ext_int_a_pin, port_c_pins, port_b_pins, port_a_pins};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= sync1;
    end
  end

  logic [23:0] pins;
  assign pins = sync2[23:0];

  // Filter sample tick.
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic       tick;

  always_comb begin
    next_div_cnt = (div_cnt == EPI_FILT_DIV_LAST) ? 2'h0 : div_cnt + 2'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  assign tick = (div_cnt == EPI_FILT_DIV_LAST);

  // Register state.
  epi_cfg_s [3:0] cfg;
  epi_cfg_s [3:0] next_cfg;
  logic [4:0]     sel_c;
  logic [4:0]     next_sel_c;
  logic [4:0]     sel_d;
  logic [4:0]     next_sel_d;
  logic [3:0]     wake_filt;
  logic [3:0]     next_wake_filt;
  logic [2:0]     dbg_cfg;
  logic [2:0]     next_dbg_cfg;
  logic [3:0]     flags;
  logic [3:0]     next_flags;

  // Write channel capture.
  logic        aw_held;
  logic        next_aw_held;
  logic        w_held;
  logic        next_w_held;
  logic [31:0] aw_addr;
  logic [31:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0]  w_strb;
  logic [3:0]  next_w_strb;
  logic        bvalid;
  logic        next_bvalid;
  logic [1:0]  bresp;
  logic [1:0]  next_bresp;
  logic        wr_go;
  logic [31:0] wmask;
  logic [31:0] wval;

  assign wr_go = aw_held & w_held & ~bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wval  = w_data & wmask;

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a == EPI_ADDR_FLAGS) || (a == EPI_ADDR_CFG_A) || (a == EPI_ADDR_CFG_B) ||
             (a == EPI_ADDR_CFG_C) || (a == EPI_ADDR_CFG_D) || (a == EPI_ADDR_SEL_C) ||
             (a == EPI_ADDR_SEL_D) || (a == EPI_ADDR_WAKE_FILT) || (a == EPI_ADDR_DBG_CFG);
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask,
                                        input logic [31:0] val);
    merge = (old & ~mask) | val;
  endfunction : merge

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? EPI_RESP_OKAY : EPI_RESP_DECERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_strb        <= '0;
      bvalid        <= 1'b0;
      bresp         <= EPI_RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      bvalid        <= next_bvalid;
      bresp         <= next_bresp;
      s_axi_awready <= ~next_aw_held;
      s_axi_wready  <= ~next_w_held;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp;

  // Source routing, filtering and trigger detection.
  function automatic logic route(input logic [4:0] code, input logic [23:0] p);
    route = (code <= EPI_SEL_LAST) ? p[code] : 1'b0;
  endfunction : route

  logic [3:0]           int_raw;
  logic [3:0]           int_filt_en;
  logic [3:0]           int_level;
  logic [3:0]           int_hit;
  epi_mode_e [3:0]      int_mode;

  assign int_raw = {route(sel_d, pins), route(sel_c, pins), sync2[25], sync2[24]};

  always_comb begin
    for (int i = 0; i < EPI_NUM_INT; i++) begin
      int_filt_en[i] = cfg[i].filt;
      int_mode[i]    = cfg[i].mode;
    end
  end

  epi_filter #(.W(4)) u_int_filter (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick),
    .en    (int_filt_en),
    .din   (int_raw),
    .dout  (int_level)
  );

  epi_trigger #(.W(4)) u_trigger (
    .clk   (clk),
    .rst_n (rst_n),
    .level (int_level),
    .mode  (int_mode),
    .hit   (int_hit)
  );

  // Wake sources: port pins, two serial pins, and interrupt D's pin.
  logic [23:0] pin_filt_en;
  logic [23:0] pin_level;
  logic [23:0] pin_prev;
  logic [23:0] next_pin_prev;
  logic        intd_level;
  logic        intd_prev;
  logic        next_intd_prev;

  always_comb begin
    pin_filt_en = port_wake_monitor_mask & {24{wake_filt[EPI_WF_PORT_BIT]}};
    if (wake_filt[EPI_WF_SER1_BIT]) begin
      pin_filt_en[EPI_IDX_PORT_B_PIN2] = 1'b1;
    end
    if (wake_filt[EPI_WF_SER2_BIT]) begin
      pin_filt_en[EPI_IDX_PORT_A_PIN2] = 1'b1;
    end
  end

  epi_filter #(.W(24)) u_pin_filter (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick),
    .en    (pin_filt_en),
    .din   (pins),
    .dout  (pin_level)
  );

  epi_filter #(.W(1)) u_intd_wake_filter (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick),
    .en    (wake_filt[EPI_WF_INTD_BIT]),
    .din   (int_raw[3]),
    .dout  (intd_level)
  );

  epi_wake_s next_wake;

  always_comb begin
    next_pin_prev  = pin_level;
    next_intd_prev = intd_level;
    next_wake.port    = |((pin_level ^ pin_prev) & port_wake_monitor_mask);
    next_wake.serial1 = pin_level[EPI_IDX_PORT_B_PIN2] ^ pin_prev[EPI_IDX_PORT_B_PIN2];
    next_wake.serial2 = pin_level[EPI_IDX_PORT_A_PIN2] ^ pin_prev[EPI_IDX_PORT_A_PIN2];
    next_wake.int_d   = intd_level ^ intd_prev;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev  <= '0;
      intd_prev <= 1'b0;
      wake      <= '0;
    end else begin
      pin_prev  <= next_pin_prev;
      intd_prev <= next_intd_prev;
      wake      <= next_wake;
    end
  end

  // Register updates; a hardware set beats a software clear in the same cycle.
  always_comb begin
    next_cfg       = cfg;
    next_sel_c     = sel_c;
    next_sel_d     = sel_d;
    next_wake_filt = wake_filt;
    next_dbg_cfg   = dbg_cfg;
    next_flags     = flags;
    if (wr_go) begin
      unique case (aw_addr)
        EPI_ADDR_CFG_A, EPI_ADDR_CFG_B, EPI_ADDR_CFG_C, EPI_ADDR_CFG_D: begin
          next_cfg[aw_addr[3:2]] = epi_cfg_s'(merge(
            {23'h0, cfg[aw_addr[3:2]], 5'h00}, wmask, wval) >> EPI_CFG_MODE_LSB);
        end
        EPI_ADDR_SEL_C:     next_sel_c = 5'(merge({27'h0, sel_c}, wmask, wval));
        EPI_ADDR_SEL_D:     next_sel_d = 5'(merge({27'h0, sel_d}, wmask, wval));
        EPI_ADDR_WAKE_FILT: next_wake_filt = 4'(merge({28'h0, wake_filt}, wmask, wval));
        EPI_ADDR_DBG_CFG:   next_dbg_cfg = 3'(merge({26'h0, dbg_cfg, 3'h0}, wmask, wval) >> 3);
        EPI_ADDR_FLAGS:     next_flags = flags & ~wval[3:0];
        default:            next_flags = flags;
      endcase
    end
    next_flags = next_flags | int_hit;
    if (debug_rsvd_load) begin
      next_dbg_cfg[0] = debug_rsvd_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg       <= '0;
      sel_c     <= EPI_SEL_C_RESET;
      sel_d     <= EPI_SEL_D_RESET;
      wake_filt <= '0;
      dbg_cfg   <= EPI_DBG_RESET;
      flags     <= '0;
    end else begin
      cfg       <= next_cfg;
      sel_c     <= next_sel_c;
      sel_d     <= next_sel_d;
      wake_filt <= next_wake_filt;
      dbg_cfg   <= next_dbg_cfg;
      flags     <= next_flags;
    end
  end

  // Outputs that follow the registers.
  logic next_permit;
  logic next_reg_ovr;

  always_comb begin
    // Once debug is running, setting the disable bit cannot cut it off.
    next_permit  = ~next_dbg_cfg[EPI_DBG_DIS_BIT - 3] | debug_active;
    next_reg_ovr = next_dbg_cfg[EPI_DBG_REG_BIT - 3];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_int_pending           <= '0;
      debug_override_permit     <= 1'b1;
      regulator_pin_override_en <= 1'b1;
    end else begin
      ext_int_pending           <= next_flags;
      debug_override_permit     <= next_permit;
      regulator_pin_override_en <= next_reg_ovr;
    end
  end

  // Read channel.
  logic [31:0] rd_word;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;

  always_comb begin
    rd_word = '0;
    unique case (s_axi_araddr)
      EPI_ADDR_FLAGS:     rd_word = {28'h0, flags};
      EPI_ADDR_CFG_A, EPI_ADDR_CFG_B, EPI_ADDR_CFG_C, EPI_ADDR_CFG_D:
        rd_word = {23'h0, cfg[s_axi_araddr[3:2]], 5'h00};
      EPI_ADDR_SEL_C:     rd_word = {27'h0, sel_c};
      EPI_ADDR_SEL_D:     rd_word = {27'h0, sel_d};
      EPI_ADDR_WAKE_FILT: rd_word = {28'h0, wake_filt};
      EPI_ADDR_DBG_CFG:   rd_word = {26'h0, dbg_cfg, 3'h0};
      default:            rd_word = '0;
    endcase
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rdata  = rd_word;
      next_rresp  = mapped(s_axi_araddr) ? EPI_RESP_OKAY : EPI_RESP_DECERR;
      next_rvalid = 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rdata   <= '0;
      s_axi_rresp   <= EPI_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
    end
  end

endmodule : epi_top

// [sim/epi_top_props.sv]
// Checker of bus timing, flag clearing and debug permit behaviour at the block ports.
`timescale 1ns/100ps
module epi_top_props
  import epi_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [3:0]  ext_int_pending,
  input wire logic        debug_active,
  input wire logic        debug_override_permit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response not two cycles after handshake");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  // The slots reopen while the response waits; the write itself still waits for bready.
  AST_ONE_WRITE: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready && !s_axi_wready)
    else $error("write channels stayed open after a handshake");
  AST_DEC_DATA: assert property (s_axi_rvalid && s_axi_rresp == EPI_RESP_DECERR
    |-> s_axi_rdata == 0)
    else $error("refused read returned data");
  AST_FLAG_CLR: assert property (|($past(ext_int_pending) & ~ext_int_pending)
    |-> $rose(s_axi_bvalid))
    else $error("pending flag fell without a write");
  AST_PERMIT_ON: assert property (debug_active |=> debug_override_permit)
    else $error("active debug lost its permit");
  AST_PERMIT_OFF: assert property ($fell(debug_override_permit) |-> !$past(debug_active))
    else $error("permit withdrawn while debug active");
endmodule : epi_top_props

bind epi_top epi_top_props u_epi_top_props (.*);

// [sim/epi_pin_model.sv]
// Model of the outside drivers on the port pins and the dedicated interrupt pins.
`timescale 1ns/100ps
module epi_pin_model (
  input  wire logic        clk,
  input  wire logic [25:0] lvl,
  output logic      [7:0]  port_a_pins,
  output logic      [7:0]  port_b_pins,
  output logic      [7:0]  port_c_pins,
  output logic             ext_int_a_pin,
  output logic             ext_int_b_pin
);
  // Push-pull drivers, so every pin always shows a real level, also at time zero.
  initial {ext_int_b_pin, ext_int_a_pin, port_c_pins, port_b_pins, port_a_pins} = '0;
  always @(posedge clk) begin
    {ext_int_b_pin, ext_int_a_pin, port_c_pins, port_b_pins, port_a_pins} <= lvl;
  end
endmodule : epi_pin_model

// [sim/epi_top_test.sv]
// Self-checking bench of the pin interrupt block: registers, triggers, routing, wake, debug.
`timescale 1ns/100ps
module epi_top_test;
  import epi_pkg::*;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rdv;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [25:0] lvl = 0;
  logic [23:0] port_wake_monitor_mask = 0;
  logic        debug_active = 0, debug_rsvd_load = 0, debug_rsvd_value = 0;
  logic [7:0]  port_a_pins, port_b_pins, port_c_pins;
  logic        ext_int_a_pin, ext_int_b_pin, debug_override_permit, regulator_pin_override_en;
  logic [3:0]  ext_int_pending;
  epi_wake_s   wake;
  int          fail_count = 0, checks = 0, wcnt[4];

  epi_top u_epi_top (.*, .s_axi_wstrb(4'hf));
  epi_pin_model u_epi_pin_model (.*);

  initial forever #2 clk = ~clk;
  always @(posedge clk) for (int k = 0; k < 4; k++) if (wake[k] === 1'b1) wcnt[k]++;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, once the next edge's inputs have settled.
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) s_axi_bready <= 0;
    end
  endtask : wr

  task rdr(input logic [31:0] a);
    logic ta, tr;
    tr = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!tr) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      rdv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 0;
      if (tr) s_axi_rready <= 0;
    end
  endtask : rdr

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task pin(input int i, input logic v);
    @(posedge clk);
    lvl[i] <= v;
    tick(40);
  endtask : pin

  // A two-cycle pulse is far shorter than the filter's three stable samples.
  task glitch(input int i);
    @(posedge clk);
    lvl[i] <= 1;
    tick(2);
    lvl[i] <= 0;
    tick(40);
  endtask : glitch

  task automatic t_regs;
    logic [31:0] ra[6] = '{EPI_ADDR_SEL_C, EPI_ADDR_SEL_D, EPI_ADDR_DBG_CFG, EPI_ADDR_FLAGS,
                           EPI_ADDR_CFG_A, EPI_ADDR_WAKE_FILT};
    logic [31:0] re[6] = '{32'h0000_000f, 32'h0000_0010, 32'h0000_0010, 0, 0, 0};
    for (int i = 0; i < 6; i++) begin
      rdr(ra[i]);
      chk(rdv, re[i]);
    end
    chk({regulator_pin_override_en, debug_override_permit}, 2'b11);
    wr(32'h4000_a900, 32'h0000_0001);
    chk(rs, EPI_RESP_DECERR);
    rdr(32'h4000_a900);
    chk(rs, EPI_RESP_DECERR);
    wr(EPI_ADDR_CFG_B, 32'hffff_ffff);
    rdr(EPI_ADDR_CFG_B);
    chk(rdv, 32'h0000_01e0);
    wr(EPI_ADDR_CFG_B, 0);
    wr(EPI_ADDR_SEL_C, 32'hffff_ffff);
    rdr(EPI_ADDR_SEL_C);
    chk(rdv, 32'h0000_001f);
  endtask : t_regs

  task t_modes;
    for (int m = 0; m < 8; m++) begin
      wr(EPI_ADDR_CFG_A, 32'(m) << EPI_CFG_MODE_LSB);
      pin(24, 0);
      wr(EPI_ADDR_FLAGS, 32'h0000_000f);
      tick(40);
      rdr(EPI_ADDR_FLAGS);
      chk(rdv, 32'(m == 5));
      pin(24, 1);
      rdr(EPI_ADDR_FLAGS);
      chk(rdv, 32'(m == 1 || m == 3 || m == 4 || m == 5));
      chk(32'(ext_int_pending), rdv);
      wr(EPI_ADDR_FLAGS, 32'h0000_0001);
      tick(40);
      rdr(EPI_ADDR_FLAGS);
      chk(rdv, 32'(m == 4));
      pin(24, 0);
      rdr(EPI_ADDR_FLAGS);
      chk(rdv, 32'(m inside {2, 3, 4, 5}));
      wr(EPI_ADDR_FLAGS, 0);
      rdr(EPI_ADDR_FLAGS);
      chk(rdv, 32'(m inside {2, 3, 4, 5}));
    end
    wr(EPI_ADDR_CFG_A, 0);
  endtask : t_modes

  task t_filter;
    for (int f = 0; f < 2; f++) begin
      wr(EPI_ADDR_CFG_B, (32'(f) << EPI_CFG_FILT_BIT) | 32'h0000_0020);
      wr(EPI_ADDR_FLAGS, 32'h0000_000f);
      glitch(25);
      rdr(EPI_ADDR_FLAGS);
      chk(rdv, f ? 32'h0 : 32'h2);
      wr(EPI_ADDR_FLAGS, 32'h0000_000f);
      pin(25, 1);
      rdr(EPI_ADDR_FLAGS);
      chk(rdv, 32'h0000_0002);
      pin(25, 0);
    end
  endtask : t_filter

  task automatic t_select;
    logic [4:0] codes[4] = '{5'h00, 5'h0a, 5'h17, 5'h18};
    wr(EPI_ADDR_CFG_C, 32'h0000_0020);
    wr(EPI_ADDR_CFG_D, 32'h0000_0020);
    for (int i = 0; i < 4; i++) begin
      wr(EPI_ADDR_SEL_C, 32'(codes[i]));
      wr(EPI_ADDR_FLAGS, 32'h0000_000f);
      glitch(i < 3 ? int'(codes[i]) : 0);
      rdr(EPI_ADDR_FLAGS);
      chk(rdv, i < 3 ? 32'h4 : 32'h0);
    end
    wr(EPI_ADDR_FLAGS, 32'h0000_000f);
    glitch(16);
    rdr(EPI_ADDR_FLAGS);
    chk(rdv, 32'h0000_0008);
  endtask : t_select

  task automatic t_wake;
    int src[4] = '{21, 10, 2, 16};
    int c0;
    port_wake_monitor_mask <= 24'h20_0000;
    for (int k = 0; k < 4; k++) begin
      for (int f = 0; f < 2; f++) begin
        wr(EPI_ADDR_WAKE_FILT, 32'(f) << k);
        c0 = wcnt[k];
        glitch(src[k]);
        chk(32'(wcnt[k] - c0), f ? 32'h0 : 32'h2);
      end
    end
    port_wake_monitor_mask <= 0;
    wr(EPI_ADDR_WAKE_FILT, 0);
    c0 = wcnt[0];
    glitch(21);
    chk(32'(wcnt[0] - c0), 0);
  endtask : t_wake

  task t_debug;
    rdr(EPI_ADDR_DBG_CFG);
    wr(EPI_ADDR_DBG_CFG, (rdv | 32'h0000_0020) & ~32'h0000_0010);
    tick(3);
    chk({regulator_pin_override_en, debug_override_permit}, 2'b00);
    debug_active <= 1;
    tick(3);
    chk(debug_override_permit, 1);
    debug_rsvd_load <= 1;
    debug_rsvd_value <= 1;
    tick(1);
    debug_rsvd_load <= 0;
    rdr(EPI_ADDR_DBG_CFG);
    chk(rdv, 32'h0000_0028);
    wr(EPI_ADDR_DBG_CFG, (rdv & ~32'h0000_0020) | 32'h0000_0010);
    debug_active <= 0;
    tick(3);
    chk({regulator_pin_override_en, debug_override_permit}, 2'b11);
  endtask : t_debug

  task close_out;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  initial begin
    #200000;
    fail_count++;
    close_out();
  end

  initial begin
    tick(12);
    rst_n <= 1;
    t_regs();
    t_modes();
    t_filter();
    t_select();
    t_wake();
    t_debug();
    close_out();
  end
endmodule : epi_top_test
